// *** fsq_bus_cycle.sv ***
// fsq_bus_cycle: one timed write or read strobe cycle on the flash pins.
// assumes data/address are held stable by the caller while busy_o is high.
`timescale 1ns/10ps
module fsq_bus_cycle (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        start_i,
  input  wire logic        is_read_i,
  input  wire logic [15:0] dq_sync_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             we_b_o,
  output logic             oe_b_o,
  output logic             ce_b_o,
  output logic             dq_oe_o,
  output logic [15:0]      rdata_o
);
  typedef enum logic [1:0] {FSQ_BC_IDLE, FSQ_BC_STROBE, FSQ_BC_RECOVER} fsq_bc_e;
  typedef struct packed {
    fsq_bc_e                   st;
    logic [fsq_pkg::CNT_W-1:0] cnt;
    logic                      rd;
    logic                      done;
    logic [15:0]               data;
    logic                      sel_on;
    logic                      wr_on;
    logic                      rd_on;
    logic                      drv;
  } fsq_bc_s;
  fsq_bc_s s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      FSQ_BC_IDLE: begin
        if (start_i) begin
          s_d.st  = FSQ_BC_STROBE;
          s_d.rd  = is_read_i;
          // read waits access time plus two sync stages
          s_d.cnt = is_read_i ? fsq_pkg::CNT_W'(fsq_pkg::ACC_CYC + 2)
                              : fsq_pkg::CNT_W'(fsq_pkg::WP_CYC);
        end
      end
      FSQ_BC_STROBE: begin
        if (s_q.cnt > 1) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          if (s_q.rd) begin
            s_d.data = dq_sync_i;
          end
          s_d.st  = FSQ_BC_RECOVER;
          s_d.cnt = fsq_pkg::CNT_W'(fsq_pkg::WPH_CYC);
        end
      end
      FSQ_BC_RECOVER: begin
        if (s_q.cnt > 1) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          s_d.st   = FSQ_BC_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = FSQ_BC_IDLE;
    endcase
    // pin strobes come straight from flops: a state and mode change cannot glitch them
    s_d.sel_on = (s_d.st == FSQ_BC_STROBE);
    s_d.wr_on  = (s_d.st == FSQ_BC_STROBE) && !s_d.rd;
    s_d.rd_on  = (s_d.st == FSQ_BC_STROBE) && s_d.rd;
    s_d.drv    = (s_d.st != FSQ_BC_IDLE) && !s_d.rd;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // strobes rise at the end of the strobe phase: data latched on that edge
  assign busy_o  = (s_q.st != FSQ_BC_IDLE);
  assign done_o  = s_q.done;
  assign ce_b_o  = !s_q.sel_on;
  assign we_b_o  = !s_q.wr_on;
  assign oe_b_o  = !s_q.rd_on;
  assign dq_oe_o = s_q.drv;
  assign rdata_o = s_q.data;
endmodule

// *** fsq_flash_model.sv ***
// fsq_flash_model: behavioural parallel flash, commands taken at end of write strobe.
// assumes osc_i times internal countdowns, reset and read output updates; block index is addr[17:14].
`timescale 1ns/10ps
module fsq_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h005A, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h00A5, // arbitrary value
  parameter int          PROG_CYC   = 20
) (
  input  wire logic        osc_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_b_i,
  input  wire logic        we_b_i,
  input  wire logic        oe_b_i,
  input  wire logic        word_i,
  input  wire logic        vpp_high_i,
  input  wire logic        boot_unlock_i,
  input  wire logic        rst_b_i,
  input  wire logic        slow_i,
  input  wire logic        vpp_bad_i,
  output logic      [15:0] dq_o
);
  typedef enum {ARR, STAT, IDN, ESET, WSET, PROG, ERAS, SUSP} fsq_mode_e;
  fsq_mode_e   mode = ARR;
  logic [15:0] mem [int];
  logic [7:0]  sr = 8'h80;
  logic [17:0] ea;
  int          cnt = 0;
  int          scnt = 0;
  bit          sarr = 1'b0;
  int          ks[$];
  wire         wr = !ce_b_i && !we_b_i;
  initial dq_o = 16'h0000;
  function automatic logic [15:0] rd_mem(input logic [17:0] x);
    return mem.exists(x) ? mem[x] : 16'hFFFF;
  endfunction
  always @(negedge wr) begin
    logic [7:0] cmd;
    logic       er;
    logic       vok;
    cmd = dq_i[7:0];
    er = (mode == ESET);
    vok = vpp_high_i && !vpp_bad_i;
    if (rst_b_i) case (mode)
      PROG: ;
      ERAS: if (cmd == 8'hB0) scnt = 2;
        else if (cmd == 8'hD0) scnt = 0;
      SUSP: begin
        if (cmd == 8'hFF) sarr = 1'b1;
        if (cmd == 8'h70) sarr = 1'b0;
        if (cmd == 8'hD0) begin
          sr[7:6] = 2'b00;
          mode = ERAS;
        end
      end
      WSET, ESET: begin
        if (!er && (word_i ? dq_i : {8'hFF, dq_i[7:0]}) == 16'hFFFF) mode = ARR;
        else if (er && cmd != 8'hD0) begin
          sr = sr | 8'hA0;
          mode = ARR;
        end else if (sr[3]) mode = STAT;
        else if (!vok || (er && addr_i[17:14] == 4'h0 && !boot_unlock_i)) begin
          sr = sr | {2'b00, er, !er, !vok, 3'b000};
          mode = STAT;
        end else begin
          if (!er) mem[addr_i] = rd_mem(addr_i) & dq_i;
          ea = addr_i;
          cnt = er ? (slow_i ? 500 : 100) : PROG_CYC;
          sr[7] = 1'b0;
          mode = er ? ERAS : PROG;
        end
      end
      default: case (cmd)
        8'hFF: mode = ARR;
        8'h90: mode = IDN;
        8'h70: mode = STAT;
        8'h50: sr[5:3] = 3'b000;
        8'h20: mode = ESET;
        8'h40, 8'h10: mode = WSET;
        default: ;
      endcase
    endcase
  end
  always @(posedge osc_i) begin
    if (!rst_b_i) begin
      mode = ARR;
      sr = 8'h80;
      scnt = 0;
      sarr = 1'b0;
    end else if (mode == ERAS && scnt > 0) begin
      scnt = scnt - 1;
      if (scnt == 0) begin
        sr[7:6] = 2'b11;
        sarr = 1'b0;
        mode = SUSP;
      end
    end else if (mode == PROG || mode == ERAS) begin
      cnt = cnt - 1;
      if (cnt == 0) begin
        ks.delete();
        if (mode == ERAS) foreach (mem[k]) if (k[17:14] == ea[17:14]) ks.push_back(k);
        foreach (ks[i]) mem.delete(ks[i]);
        sr[7] = 1'b1;
        mode = STAT;
      end
    end
  end
  // released bus toggles so a stale value can never pass as read data
  always @(negedge osc_i) begin
    if (ce_b_i || oe_b_i) dq_o = ~dq_o;
    else if (mode == ARR || (mode == SUSP && sarr)) dq_o = rd_mem(addr_i);
    else if (mode == IDN) dq_o = addr_i[0] ? PART_CODE : MAKER_CODE;
    else dq_o = {8'h00, sr};
  end
endmodule

// *** fsq_host.sv ***
// fsq_host: host-side sequencer driving a parallel flash through its command pins.
// assumes flash pins are asynchronous; dq input is synchronised before use.
// Notes on behaviour
// - after write setup alone, writing all ones cancels the program.
// - erase is 20H any address, then D0H inside block with supply high.
// - keep programming supply high until engine ready reads one.
// - boot block erase raises unlock level together with programming supply.
// - in suspension only locations outside the erasing block are read.
// - programming supply stays high throughout erase suspension; an abort op drops it even while suspended.
// - failure bits stay set until clear-status command 50H.
// - after erase, write FFH before reading array data.
// - several operations may run before a status check.
// - program is setup 40H or 10H, then address and data.
// - FFH returns the device to array read from any mode; the model ignores it while programming or erasing.
`timescale 1ns/10ps
module fsq_host #(
  parameter int unsigned POLL_LIMIT = 65535
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // user side
  input  wire logic        req_valid_i,
  input  wire logic [2:0]  req_op_i,
  input  wire logic [17:0] req_addr_i,
  input  wire logic [15:0] req_data_i,
  input  wire logic        req_word_i,
  input  wire logic        req_boot_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  output logic [7:0]       rsp_status_o,
  output logic [2:0]       rsp_error_o,
  output logic             rsp_timeout_o,
  output logic             erase_suspended_o,
  // flash pins
  output logic [17:0]      fl_addr_o,
  output logic [15:0]      fl_dq_o,
  output logic             fl_dq_oe_o,
  input  wire logic [15:0] fl_dq_i,
  output logic             fl_ce_b_o,
  output logic             fl_we_b_o,
  output logic             fl_oe_b_o,
  output logic             fl_word_o,
  output logic             fl_vpp_high_o,
  output logic             fl_boot_unlock_o,
  output logic             fl_rst_b_o
);
  initial begin
    if (POLL_LIMIT < 2 || POLL_LIMIT > 32'hFFFF_FFF0) begin
      $error("fsq_host: POLL_LIMIT out of range");
    end
  end

  typedef enum logic [3:0] {
    FSQ_RESET, FSQ_IDLE, FSQ_CMD, FSQ_DATA, FSQ_SETTLE, FSQ_POLL,
    FSQ_READ, FSQ_RELOCK, FSQ_DONE
  } fsq_state_e;

  typedef struct packed {
    fsq_state_e  st;
    logic [2:0]  op;
    logic [17:0] addr;
    logic [15:0] data;
    logic        word;
    logic        boot;
    logic        susp;
    logic        vpp;
    logic        unlock;
    logic        rst_pin;
    logic [31:0] cnt;
    logic [15:0] dq;
    logic [17:0] pin_addr;
    logic [15:0] rdata;
    logic [7:0]  status;
    logic        rvalid;
    logic        tmo;
    logic        go;
    logic        go_rd;
    logic [1:0]  step;
  } fsq_s;
  fsq_s s_q, s_d;

  logic [15:0] dq_meta_q, dq_sync_q;
  logic        bc_busy, bc_done, bc_dq_oe;
  logic [15:0] bc_rdata;

  always_ff @(posedge clk_sys_i) begin
    dq_meta_q <= fl_dq_i;
    dq_sync_q <= dq_meta_q;
  end

  fsq_bus_cycle u_cycle (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (s_q.go),
    .is_read_i (s_q.go_rd),
    .dq_sync_i (dq_sync_q),
    .busy_o    (bc_busy),
    .done_o    (bc_done),
    .we_b_o    (fl_we_b_o),
    .oe_b_o    (fl_oe_b_o),
    .ce_b_o    (fl_ce_b_o),
    .dq_oe_o   (bc_dq_oe),
    .rdata_o   (bc_rdata)
  );

  // first command byte for each operation
  function automatic logic [7:0] fsq_first_cmd(input logic [2:0] op);
    case (fsq_pkg::fsq_op_e'(op))
      fsq_pkg::FSQ_OP_PROGRAM: fsq_first_cmd = fsq_pkg::CMD_WRITE_SETUP;
      fsq_pkg::FSQ_OP_ABORT:   fsq_first_cmd = fsq_pkg::CMD_WRITE_SETUP;
      fsq_pkg::FSQ_OP_ERASE:   fsq_first_cmd = fsq_pkg::CMD_ERASE_SETUP;
      fsq_pkg::FSQ_OP_SUSPEND: fsq_first_cmd = fsq_pkg::CMD_SUSPEND;
      fsq_pkg::FSQ_OP_RESUME:  fsq_first_cmd = fsq_pkg::CMD_CONFIRM;
      fsq_pkg::FSQ_OP_CLEAR:   fsq_first_cmd = fsq_pkg::CMD_CLEAR_STATUS;
      fsq_pkg::FSQ_OP_IDENT:   fsq_first_cmd = fsq_pkg::CMD_IDENTIFY;
      default:                 fsq_first_cmd = fsq_pkg::CMD_READ_ARRAY;
    endcase
  endfunction

  always_comb begin
    s_d        = s_q;
    s_d.go     = 1'b0;
    s_d.rvalid = 1'b0;
    case (s_q.st)
      FSQ_RESET: begin
        // hold flash reset low, then wait recovery before first strobe
        s_d.rst_pin = 1'b0;
        s_d.cnt     = s_q.cnt + 1'b1;
        if (s_q.cnt >= 32'(fsq_pkg::RS_CYC)) begin
          s_d.rst_pin = 1'b1;
        end
        if (s_q.cnt >= 32'(2 * fsq_pkg::RS_CYC)) begin
          s_d.rst_pin = 1'b1;
          s_d.st      = FSQ_IDLE;
        end
      end
      FSQ_IDLE: begin
        if (req_valid_i) begin
          s_d.op   = req_op_i;
          s_d.addr = req_addr_i;
          s_d.data = req_data_i;
          s_d.word = req_word_i;
          s_d.boot = req_boot_i;
          s_d.tmo  = 1'b0;
          s_d.dq   = {8'h00, fsq_first_cmd(req_op_i)};
          s_d.pin_addr = 18'h00000;
          // raise supply ahead of the cycle that needs it
          if (req_op_i == 3'(fsq_pkg::FSQ_OP_PROGRAM) ||
              req_op_i == 3'(fsq_pkg::FSQ_OP_ERASE)) begin
            s_d.vpp    = 1'b1;
            s_d.unlock = req_boot_i;
          end
          s_d.go    = 1'b1;
          s_d.go_rd = 1'b0;
          s_d.st    = FSQ_CMD;
        end
      end
      FSQ_CMD: begin
        if (bc_done) begin
          case (fsq_pkg::fsq_op_e'(s_q.op))
            fsq_pkg::FSQ_OP_PROGRAM, fsq_pkg::FSQ_OP_ERASE, fsq_pkg::FSQ_OP_ABORT: begin
              s_d.pin_addr = s_q.addr;
              if (s_q.op == 3'(fsq_pkg::FSQ_OP_ERASE)) begin
                s_d.dq = {8'h00, fsq_pkg::CMD_CONFIRM};
              end else if (s_q.op == 3'(fsq_pkg::FSQ_OP_ABORT)) begin
                s_d.dq = s_q.word ? fsq_pkg::NULL_WORD
                                  : {8'h00, fsq_pkg::NULL_BYTE};
              end else begin
                s_d.dq = s_q.data;
              end
              s_d.cnt = 32'(fsq_pkg::VPS_CYC);
              s_d.st  = FSQ_DATA;
            end
            fsq_pkg::FSQ_OP_SUSPEND: begin
              s_d.cnt = 32'h0;
              s_d.st  = FSQ_SETTLE;
            end
            fsq_pkg::FSQ_OP_RESUME: begin
              s_d.susp = 1'b0;
              s_d.cnt  = 32'h0;
              s_d.st   = FSQ_SETTLE;
            end
            fsq_pkg::FSQ_OP_READ, fsq_pkg::FSQ_OP_IDENT: begin
              s_d.pin_addr = (s_q.op == 3'(fsq_pkg::FSQ_OP_IDENT))
                ? (s_q.addr[0] ? fsq_pkg::IDENT_ADDR_PART
                               : fsq_pkg::IDENT_ADDR_MAKER)
                : s_q.addr;
              s_d.go    = 1'b1;
              s_d.go_rd = 1'b1;
              s_d.st    = FSQ_READ;
            end
            default: begin
              s_d.st = FSQ_DONE;
            end
          endcase
        end
      end
      FSQ_DATA: begin
        // supply setup time before the latching strobe
        if (s_q.cnt > 0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          s_d.go    = 1'b1;
          s_d.go_rd = 1'b0;
          s_d.st    = FSQ_SETTLE;
        end
      end
      FSQ_SETTLE: begin
        if (!bc_busy && !s_q.go) begin
          s_d.cnt = 32'h0;
          // abort performs no programming, so there is nothing to poll
          s_d.st  = (s_q.op == 3'(fsq_pkg::FSQ_OP_ABORT)) ? FSQ_DONE : FSQ_POLL;
          if (s_q.op == 3'(fsq_pkg::FSQ_OP_ABORT)) begin
            s_d.vpp = 1'b0;
          end else begin
            s_d.go    = 1'b1;
            s_d.go_rd = 1'b1;
          end
        end
      end
      FSQ_POLL: begin
        // device shows status on reads while busy; no command is sent
        if (bc_done) begin
          s_d.status = bc_rdata[7:0];
          s_d.cnt    = s_q.cnt + 1'b1;
          if (bc_rdata[fsq_pkg::ENGINE_READY_BIT]) begin
            if (s_q.op == 3'(fsq_pkg::FSQ_OP_SUSPEND)) begin
              s_d.susp = bc_rdata[fsq_pkg::SUSPEND_FLAG_BIT];
              s_d.st   = FSQ_DONE;
            end else begin
              s_d.cnt = 32'(fsq_pkg::REL_CYC);
              s_d.st  = FSQ_RELOCK;
            end
          end else if (s_q.cnt >= 32'(POLL_LIMIT)) begin
            // supply kept high: a stuck device is reported, not abandoned
            s_d.tmo = 1'b1;
            s_d.st  = FSQ_DONE;
          end else begin
            s_d.go    = 1'b1;
            s_d.go_rd = 1'b1;
          end
        end
      end
      FSQ_RELOCK: begin
        s_d.unlock = 1'b0;
        // supply stays high while erase is merely suspended
        s_d.vpp = s_q.susp;
        if (s_q.cnt > 0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          s_d.st = FSQ_DONE;
        end
      end
      FSQ_READ: begin
        if (bc_done) begin
          s_d.rdata = bc_rdata;
          s_d.st    = FSQ_DONE;
        end
      end
      FSQ_DONE: begin
        s_d.rvalid = 1'b1;
        s_d.st     = FSQ_IDLE;
      end
      default: s_d.st = FSQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready_o       = (s_q.st == FSQ_IDLE);
  assign rsp_valid_o       = s_q.rvalid;
  assign rsp_data_o        = s_q.rdata;
  assign rsp_status_o      = s_q.status;
  // erase-fail, write-fail, supply-missing; sticky in the device
  assign rsp_error_o       = {s_q.status[fsq_pkg::ERASE_FAIL_BIT],
                              s_q.status[fsq_pkg::WRITE_FAIL_BIT],
                              s_q.status[fsq_pkg::SUPPLY_MISSING_BIT]};
  assign rsp_timeout_o     = s_q.tmo;
  assign erase_suspended_o = s_q.susp;
  assign fl_addr_o         = s_q.pin_addr;
  assign fl_dq_o           = s_q.dq;
  assign fl_dq_oe_o        = bc_dq_oe;
  assign fl_word_o         = s_q.word;
  assign fl_vpp_high_o     = s_q.vpp;
  assign fl_boot_unlock_o  = s_q.unlock;
  assign fl_rst_b_o        = s_q.rst_pin;
endmodule

// *** fsq_host_asserts.sv ***
// fsq_host_asserts: port checks for the flash host sequencer.
// assumes one clock and a synchronous active-low reset; bound onto fsq_host.
`timescale 1ns/10ps
module fsq_host_asserts (
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic        req_valid_i,
  input wire logic        req_ready_o,
  input wire logic        rsp_valid_o,
  input wire logic        erase_suspended_o,
  input wire logic [17:0] fl_addr_o,
  input wire logic [15:0] fl_dq_o,
  input wire logic        fl_dq_oe_o,
  input wire logic        fl_ce_b_o,
  input wire logic        fl_we_b_o,
  input wire logic        fl_oe_b_o,
  input wire logic        fl_vpp_high_o,
  input wire logic        fl_boot_unlock_o,
  input wire logic        fl_rst_b_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_flash_rst_hold: assert property ($rose(rst_b_i) |-> !fl_rst_b_o [*8])
    else $error("flash reset released early");
  a_ready_late: assert property ($rose(rst_b_i) |-> !req_ready_o [*8])
    else $error("request accepted before flash reset done");
  a_write_select: assert property (!fl_we_b_o |-> !fl_ce_b_o && fl_oe_b_o && fl_dq_oe_o)
    else $error("write strobe without select or data drive");
  a_write_pulse: assert property ($fell(fl_we_b_o) |=> fl_we_b_o)
    else $error("write strobe width wrong");
  a_write_hold: assert property ($rose(fl_we_b_o) |-> $stable(fl_addr_o) && $stable(fl_dq_o))
    else $error("address or data moved at strobe end");
  a_confirm_supply: assert property (!fl_we_b_o && fl_dq_o[7:0] == 8'hD0
    |-> fl_vpp_high_o && $past(fl_vpp_high_o)) else $error("confirm without supply");
  a_read_bus_free: assert property (!fl_oe_b_o |-> !fl_dq_oe_o && fl_we_b_o)
    else $error("bus driven during read");
  a_suspend_supply: assert property (erase_suspended_o |-> fl_vpp_high_o)
    else $error("supply dropped while suspended");
  a_boot_supply: assert property ($rose(fl_boot_unlock_o) |-> fl_vpp_high_o)
    else $error("unlock raised without supply");
  a_rsp_single: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response longer than one cycle");
  a_take_busy: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("ready stayed high after a request");
  c_suspend: cover property ($rose(erase_suspended_o));
  c_boot: cover property ($rose(fl_boot_unlock_o));
  c_take: cover property (req_valid_i && req_ready_o);
endmodule

bind fsq_host fsq_host_asserts i_fsq_host_asserts (.clk_sys_i, .rst_b_i, .req_valid_i,
  .req_ready_o, .rsp_valid_o, .erase_suspended_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o,
  .fl_ce_b_o, .fl_we_b_o, .fl_oe_b_o, .fl_vpp_high_o, .fl_boot_unlock_o, .fl_rst_b_o);

// *** fsq_pkg.sv ***
// fsq_pkg: command codes, status bit positions and bus timing for the flash host sequencer.
// assumes a 10 MHz system clock; all timing counts derive from it.
package fsq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // strobe, supply and reset timing, ns as printed
  localparam int unsigned T_WP_NS       = 100;
  localparam int unsigned T_WPH_NS      = 30;
  localparam int unsigned T_ACC_NS      = 100;
  localparam int unsigned T_VPS_NS      = 200;
  localparam int unsigned T_RS_NS       = 1000;
  localparam int unsigned T_REL_NS      = 200;
  // least times round up to whole cycles
  localparam int unsigned WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned VPS_CYC = (T_VPS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RS_CYC  = (T_RS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REL_CYC = (T_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W   = 8;

  // command codes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_IDENTIFY     = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
  localparam logic [7:0] CMD_WRITE_ALT    = 8'h10;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [15:0] NULL_WORD       = 16'hFFFF;
  localparam logic [7:0]  NULL_BYTE       = 8'hFF;
  localparam logic [17:0] IDENT_ADDR_MAKER = 18'h00000;
  localparam logic [17:0] IDENT_ADDR_PART  = 18'h00001;

  // status bit positions
  localparam int unsigned ENGINE_READY_BIT   = 7;
  localparam int unsigned SUSPEND_FLAG_BIT   = 6;
  localparam int unsigned ERASE_FAIL_BIT     = 5;
  localparam int unsigned WRITE_FAIL_BIT     = 4;
  localparam int unsigned SUPPLY_MISSING_BIT = 3;

  // user operations
  typedef enum logic [2:0] {
    FSQ_OP_READ,
    FSQ_OP_PROGRAM,
    FSQ_OP_ERASE,
    FSQ_OP_SUSPEND,
    FSQ_OP_RESUME,
    FSQ_OP_CLEAR,
    FSQ_OP_IDENT,
    FSQ_OP_ABORT
  } fsq_op_e;
endpackage

// *** tb_fsq_host.sv ***
// tb_fsq_host: self-checking bench, host sequencer against a behavioural flash.
// assumes package, design, checker and flash model are compiled before it.
`timescale 1ns/10ps
module tb_fsq_host;
  localparam logic [15:0] MAKER = 16'h005A; // arbitrary value
  localparam logic [15:0] PART  = 16'h00A5; // arbitrary value
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic [2:0]  req_op_i = 3'h0;
  logic [17:0] req_addr_i = 18'h00000;
  logic [15:0] req_data_i = 16'h0000;
  logic        req_word_i = 1'b1;
  logic        req_boot_i = 1'b0;
  logic        slow = 1'b0;
  logic        vpp_bad = 1'b0;
  logic        req_ready_o, rsp_valid_o, rsp_timeout_o, erase_suspended_o, fl_word_o;
  logic [15:0] rsp_data_o, fl_dq_o, dq_dev;
  logic [7:0]  rsp_status_o;
  logic [2:0]  rsp_error_o;
  logic [17:0] fl_addr_o;
  logic        fl_dq_oe_o, fl_ce_b_o, fl_we_b_o, fl_oe_b_o;
  logic        fl_vpp_high_o, fl_boot_unlock_o, fl_rst_b_o;
  wire  [15:0] dq_bus = fl_dq_oe_o ? fl_dq_o : dq_dev;
  int          fails = 0;
  int          comparisons = 0;
  int          seed;
  logic [15:0] ref_mem [int];
  logic [17:0] a [4];
  logic [15:0] d;
  always #50 clk_sys_i = ~clk_sys_i;
  fsq_host #(.POLL_LIMIT(50)) i_fsq_host (.clk_sys_i, .rst_b_i, .req_valid_i, .req_op_i,
    .req_addr_i, .req_data_i, .req_word_i, .req_boot_i, .req_ready_o, .rsp_valid_o,
    .rsp_data_o, .rsp_status_o, .rsp_error_o, .rsp_timeout_o, .erase_suspended_o,
    .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i(dq_bus), .fl_ce_b_o, .fl_we_b_o, .fl_oe_b_o,
    .fl_word_o, .fl_vpp_high_o, .fl_boot_unlock_o, .fl_rst_b_o);
  fsq_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_fsq_flash_model (
    .osc_i(clk_sys_i), .addr_i(fl_addr_o), .dq_i(dq_bus), .ce_b_i(fl_ce_b_o),
    .we_b_i(fl_we_b_o), .oe_b_i(fl_oe_b_o), .word_i(fl_word_o), .vpp_high_i(fl_vpp_high_o),
    .boot_unlock_i(fl_boot_unlock_o), .rst_b_i(fl_rst_b_o), .slow_i(slow),
    .vpp_bad_i(vpp_bad), .dq_o(dq_dev));
  function automatic logic [15:0] exp_rd(input logic [17:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : 16'hFFFF;
  endfunction
  task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_stat(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run_op(input fsq_pkg::fsq_op_e op, input logic [17:0] x, input logic [15:0] y);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    req_op_i = op;
    req_addr_i = x;
    req_data_i = y;
    req_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    req_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    cmp_stat({7'h00, rsp_valid_o}, 8'h01);
  endtask
  task automatic rd(input logic [17:0] x);
    run_op(fsq_pkg::FSQ_OP_READ, x, 16'h0000);
  endtask
  task automatic pg(input logic [17:0] x, input logic [15:0] y);
    run_op(fsq_pkg::FSQ_OP_PROGRAM, x, y);
  endtask
  task automatic test_end(input string s);
    $display("test done: %s, fails so far %0d", s, fails);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // whole run needs well under 15000 cycles
  initial begin
    #4000000;
    fails++;
    give_verdict();
  end
  initial begin
    seed = $urandom(48);
    repeat (3) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    foreach (a[i]) a[i] = {(i == 3) ? 4'h3 : 4'h1, 14'($urandom)};
    rd(a[0]);
    cmp_data(rsp_data_o, 16'hFFFF);
    for (int i = 0; i < 2; i++) begin
      run_op(fsq_pkg::FSQ_OP_IDENT, 18'(i), 16'h0000);
      cmp_data(rsp_data_o, i ? PART : MAKER);
    end
    test_end("reset and identify");
    foreach (a[i]) begin
      d = 16'($urandom);
      ref_mem[a[i]] = exp_rd(a[i]) & d;
      pg(a[i], d);
      cmp_stat(rsp_status_o, 8'h80);
    end
    foreach (a[i]) begin
      rd(a[i]);
      cmp_data(rsp_data_o, exp_rd(a[i]));
    end
    for (int w = 0; w < 2; w++) begin
      req_word_i = w[0];
      run_op(fsq_pkg::FSQ_OP_ABORT, a[0], 16'h0000);
      req_word_i = 1'b1;
      rd(a[0]);
      cmp_data(rsp_data_o, exp_rd(a[0]));
    end
    test_end("program and abort");
    // locked boot erase fails, flag sticks through the unlocked one
    for (int b = 0; b < 3; b++) begin
      req_boot_i = (b == 1);
      run_op(fsq_pkg::FSQ_OP_ERASE, {(b == 2) ? 4'h1 : 4'h0, 14'($urandom)}, 16'h0000);
      cmp_stat(rsp_status_o, (b == 2) ? 8'h80 : 8'hA0);
      cmp_stat({5'h00, rsp_error_o}, (b == 2) ? 8'h00 : 8'h04);
      if (b == 1) run_op(fsq_pkg::FSQ_OP_CLEAR, 18'h00000, 16'h0000);
    end
    foreach (a[i]) if (i < 3) ref_mem.delete(a[i]);
    rd(a[1]);
    cmp_data(rsp_data_o, 16'hFFFF);
    test_end("block erase");
    req_boot_i = 1'b0;
    slow = 1'b1;
    run_op(fsq_pkg::FSQ_OP_ERASE, {4'h2, 14'($urandom)}, 16'h0000);
    cmp_stat({7'h00, rsp_timeout_o}, 8'h01);
    run_op(fsq_pkg::FSQ_OP_SUSPEND, 18'h00000, 16'h0000);
    cmp_stat(rsp_status_o, 8'hC0);
    cmp_stat({7'h00, erase_suspended_o}, 8'h01);
    rd(a[3]);
    cmp_data(rsp_data_o, exp_rd(a[3]));
    run_op(fsq_pkg::FSQ_OP_RESUME, 18'h00000, 16'h0000);
    cmp_stat(rsp_status_o, 8'h80);
    slow = 1'b0;
    test_end("erase suspend and resume");
    vpp_bad = 1'b1;
    pg(a[0], 16'h0000);
    cmp_stat({5'h00, rsp_error_o}, 8'h03);
    vpp_bad = 1'b0;
    pg(a[3], 16'h0000);
    cmp_stat(rsp_status_o, 8'h98);
    run_op(fsq_pkg::FSQ_OP_CLEAR, 18'h00000, 16'h0000);
    d = 16'($urandom);
    ref_mem[a[3]] = exp_rd(a[3]) & d;
    pg(a[3], d);
    cmp_stat(rsp_status_o, 8'h80);
    rd(a[3]);
    cmp_data(rsp_data_o, exp_rd(a[3]));
    test_end("supply fault");
    give_verdict();
  end
endmodule
